// [shared/daclu_pkg.sv]
/*
 * daclu_pkg: register offsets, field positions, reset values and encodings
 * for the DAC latch update control block.
 * Assumes a 16-bit register port with byte offsets as printed.
 */
package daclu_pkg;

	// register offsets (byte addresses on the register port)
	localparam logic [3:0] OFF_CONTROL = 4'h4;
	localparam logic [3:0] OFF_SAMPLE = 4'h6;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam logic [3:0] OFF_VECTOR = 4'hA;
	localparam logic [3:0] OFF_MASK = 4'hC;

	// control field positions
	localparam int CTL_CONV_EN = 0;
	localparam int CTL_IRQ_EN = 1;
	localparam int CTL_DMA_EN = 2;
	localparam int CTL_LSEL_LO = 8;
	localparam int CTL_LSEL_HI = 9;
	localparam int CTL_REF_SEL = 12;
	localparam int CTL_ENC = 13;

	// status field positions
	localparam int STS_UPDATE = 0;

	// reset values
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [11:0] SAMPLE_RESET = 12'h000;
	localparam logic [15:0] MASK_RESET = 16'h0001;

	// vector values
	localparam logic [15:0] VEC_NONE = 16'h0000;
	localparam logic [15:0] VEC_UPDATE = 16'h0004;

	// load trigger select encodings
	typedef enum logic [1:0] {
		DACLU_LOAD_ON_WRITE = 2'h0,
		DACLU_LOAD_RSVD = 2'h1,
		DACLU_LOAD_TRIG0 = 2'h2,
		DACLU_LOAD_TRIG1 = 2'h3
	} daclu_lsel_t;

endpackage : daclu_pkg

// [core/daclu_sync.sv]
/*
 * daclu_sync: two-flop synchroniser with a rising edge pulse behind it.
 * Assumes the input is asynchronous to CLOCK; the edge detector looks
 * only at the second and third stages.
 */
module daclu_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// async level in
	input wire logic async_in,
	// synchronised level and rising edge
	output logic level,
	output logic rise
);

	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	logic last_q;
	logic last_d;

	// next values of the synchroniser chain
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
		last_d = sync_q;
	end

	// register the chain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	// outputs from the settled stages only
	assign level = sync_q;
	assign rise = sync_q & ~last_q;

endmodule : daclu_sync

// [core/daclu_core.sv]
/*
 * daclu_core: digital control for a 12-bit DAC latch: control, sample,
 * status, vector and mask registers, trigger-driven latch loads, DMA
 * request and interrupt generation.
 * Assumes a 16-bit register port on CLOCK with one-cycle strobes, word
 * accesses only, and asynchronous trigger inputs from timers.
 */
// Implementation choice: the strobed register port.
//
// Functional notes
// R1 - ref select bit picks primary reference when clear, secondary when set
// R2 - load select 00 loads latch on each sample write; 01 reserved
// R3 - load select 10/11 loads latch on rising edge of trigger 0/1
// R4 - nonzero load select updates latch only with conversion enable set
// R5 - DMA enable issues a DMA request on every latch update
// R6 - interrupt enable bit in control gates the flag, resets disabled
// R7 - sample register holds 12-bit right-justified value, reset zero
// R8 - sample bits 15..12 read zero, writes to them ignored
// R9 - software and DMA use 16-bit word accesses only to sample register
// R10 - status writes accepted only while converter enable is clear
// R11 - update flag sets whenever the latch is updated
// R12 - writing one clears update flag, zero leaves it
// R13 - reading the vector register clears the update flag
// R14 - with DMA enabled, accepted DMA request clears the update flag
// R15 - vector reads 0004 while flag pending, 0000 otherwise
// R16 - interrupt output high while flag and interrupt enable both set; code also requires mask bit 0 set
module daclu_core #(
	parameter int DATA_BITS = 12
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET_N,
	// register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	// load triggers, asynchronous
	input wire logic TRIG0,
	input wire logic TRIG1,
	// DMA handshake
	output logic DMA_REQ,
	input wire logic DMA_ACK,
	// analog side
	output logic [11:0] DAC_LATCH,
	output logic DAC_REF_SEL,
	output logic DAC_ENABLE,
	// interrupt
	output logic IRQ
);

	initial begin
		if (DATA_BITS != 12) begin
			$error("daclu_core: only 12 data bits supported");
		end
	end

	// control fields
	logic [15:0] ctl_q;
	logic [15:0] ctl_d;
	logic [11:0] sample_q;
	logic [11:0] sample_d;
	logic [11:0] latch_q;
	logic [11:0] latch_d;
	logic flag_q;
	logic flag_d;
	logic mask_q;
	logic mask_d;
	logic dma_q;
	logic dma_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;

	logic trig0_rise;
	logic trig1_rise;
	logic conv_en;
	logic irq_en;
	logic dma_en;
	logic enc;
	logic [1:0] lsel;
	logic wr_sample;
	logic load;

	// trigger synchronisers
	daclu_sync u_sync0 (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.async_in(TRIG0),
		.level(),
		.rise(trig0_rise)
	);

	daclu_sync u_sync1 (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.async_in(TRIG1),
		.level(),
		.rise(trig1_rise)
	);

	// decode helper for writes
	function automatic logic wr_hit(input logic [3:0] off);
		wr_hit = REG_WR && (REG_ADDR == off);
	endfunction : wr_hit

	// control field views
	assign conv_en = ctl_q[daclu_pkg::CTL_CONV_EN];
	assign irq_en = ctl_q[daclu_pkg::CTL_IRQ_EN];
	assign dma_en = ctl_q[daclu_pkg::CTL_DMA_EN];
	assign enc = ctl_q[daclu_pkg::CTL_ENC];
	assign lsel = ctl_q[daclu_pkg::CTL_LSEL_HI:daclu_pkg::CTL_LSEL_LO];
	assign wr_sample = wr_hit(daclu_pkg::OFF_SAMPLE);

	// latch load decision
	always_comb begin
		load = 1'b0;
		case (daclu_pkg::daclu_lsel_t'(lsel))
			daclu_pkg::DACLU_LOAD_ON_WRITE: load = wr_sample; // R2 R4
			daclu_pkg::DACLU_LOAD_TRIG0: load = trig0_rise & enc; // R3 R4
			daclu_pkg::DACLU_LOAD_TRIG1: load = trig1_rise & enc; // R3 R4
			default: load = 1'b0; // R2
		endcase
	end

	// control register writes, held while converter is enabled except enable and trigger-enable
	always_comb begin
		ctl_d = ctl_q;
		if (wr_hit(daclu_pkg::OFF_CONTROL) && !conv_en) begin
			ctl_d = 16'h0000;
			ctl_d[daclu_pkg::CTL_REF_SEL] =
				REG_WDATA[daclu_pkg::CTL_REF_SEL]; // R1
			ctl_d[daclu_pkg::CTL_LSEL_HI:daclu_pkg::CTL_LSEL_LO] =
				REG_WDATA[daclu_pkg::CTL_LSEL_HI:daclu_pkg::CTL_LSEL_LO];
			ctl_d[daclu_pkg::CTL_DMA_EN] = REG_WDATA[daclu_pkg::CTL_DMA_EN];
			ctl_d[daclu_pkg::CTL_IRQ_EN] = REG_WDATA[daclu_pkg::CTL_IRQ_EN];
			ctl_d[daclu_pkg::CTL_ENC] = REG_WDATA[daclu_pkg::CTL_ENC];
			ctl_d[daclu_pkg::CTL_CONV_EN] =
				REG_WDATA[daclu_pkg::CTL_CONV_EN];
		end else if (wr_hit(daclu_pkg::OFF_CONTROL)) begin
			// enable and trigger-enable stay writable to stop the DAC
			ctl_d[daclu_pkg::CTL_CONV_EN] =
				REG_WDATA[daclu_pkg::CTL_CONV_EN];
			ctl_d[daclu_pkg::CTL_ENC] = REG_WDATA[daclu_pkg::CTL_ENC];
		end
	end

	// sample register and latch
	always_comb begin
		sample_d = sample_q;
		latch_d = latch_q;
		if (wr_sample) begin
			sample_d = REG_WDATA[11:0]; // R7 R8
		end
		if (load) begin
			// a write-triggered load takes the new word directly
			latch_d = wr_sample ? REG_WDATA[11:0] : sample_q; // R2 R3
		end
	end

	// update flag: set wins over every clear
	always_comb begin
		flag_d = flag_q;
		if (wr_hit(daclu_pkg::OFF_STATUS) && !conv_en &&
			REG_WDATA[daclu_pkg::STS_UPDATE]) begin
			flag_d = 1'b0; // R10 R12
		end
		if (REG_RD && REG_ADDR == daclu_pkg::OFF_VECTOR) begin
			flag_d = 1'b0; // R13
		end
		if (dma_en && dma_q && DMA_ACK) begin
			flag_d = 1'b0; // R14
		end
		if (load) begin
			flag_d = 1'b1; // R11
		end
	end

	// DMA request: held until acknowledged or DMA enable is cleared
	always_comb begin
		dma_d = dma_q;
		if (DMA_ACK || !dma_en) begin
			dma_d = 1'b0;
		end
		if (load && dma_en) begin
			dma_d = 1'b1; // R5
		end
	end

	// interrupt mask register
	always_comb begin
		mask_d = mask_q;
		if (wr_hit(daclu_pkg::OFF_MASK)) begin
			mask_d = REG_WDATA[0];
		end
	end

	// read data, one cycle after the strobe
	always_comb begin
		rdata_d = 16'h0000;
		if (REG_RD) begin
			case (REG_ADDR)
				daclu_pkg::OFF_CONTROL: rdata_d = ctl_q;
				daclu_pkg::OFF_SAMPLE: rdata_d = {4'h0, sample_q}; // R8
				daclu_pkg::OFF_STATUS: rdata_d = {15'h0000, flag_q}; // R11
				daclu_pkg::OFF_VECTOR: rdata_d = flag_q ?
					daclu_pkg::VEC_UPDATE : daclu_pkg::VEC_NONE; // R15
				daclu_pkg::OFF_MASK: rdata_d = {15'h0000, mask_q};
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	// register all state
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctl_q <= daclu_pkg::CONTROL_RESET; // R6
			sample_q <= daclu_pkg::SAMPLE_RESET; // R7
			latch_q <= daclu_pkg::SAMPLE_RESET;
			flag_q <= 1'b0;
			mask_q <= daclu_pkg::MASK_RESET[0];
			dma_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			ctl_q <= ctl_d;
			sample_q <= sample_d;
			latch_q <= latch_d;
			flag_q <= flag_d;
			mask_q <= mask_d;
			dma_q <= dma_d;
			rdata_q <= rdata_d;
		end
	end

	// outputs
	assign REG_RDATA = rdata_q;
	assign DMA_REQ = dma_q; // R5
	assign DAC_LATCH = latch_q;
	assign DAC_REF_SEL = ctl_q[daclu_pkg::CTL_REF_SEL]; // R1
	assign DAC_ENABLE = conv_en;
	assign IRQ = flag_q & irq_en & mask_q; // R6 R16

endmodule : daclu_core

// [sim/daclu_dma_model.sv]
/* daclu_dma_model: dma side, accepts each request after a set wait.
   assumes one clock shared with the core. */
module daclu_dma_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// wait, request and accept
	input wire logic [3:0] delay,
	input wire logic req,
	output logic ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q, cnt_d;
	logic ack_q, ack_d;
	// count the wait, accept for one cycle
	always_comb begin
		ack_d = req && !ack_q && cnt_q == delay;
		cnt_d = (req && !ack_q && !ack_d) ? cnt_q + 4'h1 : 4'h0;
	end
	// register count and accept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			ack_q <= ack_d;
		end
	end
	assign ack = ack_q;
endmodule : daclu_dma_model

// [sim/daclu_chk_assertions.sv]
/* daclu_chk: port assertions for daclu_core.
   assumes one clock domain; a cleared mask only silences IRQ. */
module daclu_chk (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET_N,
	// register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_RDATA,
	// dma, analog side, interrupt
	input wire logic DMA_REQ,
	input wire logic DMA_ACK,
	input wire logic [11:0] DAC_LATCH,
	input wire logic DAC_REF_SEL,
	input wire logic DAC_ENABLE,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] ctl_q, ctl_d;
	logic sw;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	// control shadow, bits 0 and 13 only while enabled
	always_comb begin
		ctl_d = ctl_q;
		if (REG_WR && REG_ADDR == 4'h4)
			ctl_d = ctl_q[0] ? {ctl_q[15:14], REG_WDATA[13],
				ctl_q[12:1], REG_WDATA[0]} : REG_WDATA & 16'h3307;
	end
	// register shadow
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N)
			ctl_q <= 16'h0000;
		else
			ctl_q <= ctl_d;
	end
	assign sw = REG_WR && REG_ADDR == 4'h6;
	sequence s_vrd; REG_RD && REG_ADDR == 4'hA && IRQ; endsequence
	sequence s_ack; DMA_REQ && DMA_ACK && ctl_q[2] && IRQ && !sw; endsequence
	property p_ref; DAC_REF_SEL == ctl_q[12] && DAC_ENABLE == ctl_q[0];
	endproperty
	property p_wld; sw && ctl_q[9:8] == 2'h0 |=>
		DAC_LATCH == $past(REG_WDATA[11:0]); endproperty
	property p_hold; ctl_q[9:8] == 2'h1 || (ctl_q[9] && !ctl_q[13]) |=>
		$stable(DAC_LATCH); endproperty
	property p_dma; !ctl_q[2] && !DMA_REQ |=> !DMA_REQ; endproperty
	property p_irq; IRQ |-> ctl_q[1]; endproperty
	property p_vec; s_vrd |=> REG_RDATA == 16'h0004 && !IRQ; endproperty
	property p_lock; REG_WR && REG_ADDR == 4'h8 && ctl_q[0] && IRQ |=> IRQ;
	endproperty
	property p_w1c; REG_WR && REG_ADDR == 4'h8 && !ctl_q[0] &&
		REG_WDATA[0] && IRQ |=> !IRQ; endproperty
	property p_dack; s_ack |=> !IRQ && !DMA_REQ; endproperty
	a_ref: assert property (p_ref) else $error("ref");
	a_wld: assert property (p_wld) else $error("wld");
	a_hold: assert property (p_hold) else $error("hold");
	a_dma: assert property (p_dma) else $error("dma");
	a_irq: assert property (p_irq) else $error("irq");
	a_vec: assert property (p_vec) else $error("vec");
	a_lock: assert property (p_lock) else $error("lock");
	a_w1c: assert property (p_w1c) else $error("w1c");
	a_dack: assert property (p_dack) else $error("dack");
endmodule : daclu_chk
bind daclu_core daclu_chk u_daclu_chk (.CLOCK, .RESET_N, .REG_ADDR,
	.REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .DMA_REQ, .DMA_ACK,
	.DAC_LATCH, .DAC_REF_SEL, .DAC_ENABLE, .IRQ);

// [sim/tb.sv]
/* tb: random and corner tests of daclu_core with a dma partner.
   assumes the checker file is compiled alongside. */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, t0 = 0, t1 = 0;
	logic [3:0] addr = 4'h0, dly = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata;
	logic dreq, dack, refsel, den, irq;
	logic [11:0] latch, d, o;
	int errors = 0, checks = 0, cyc = 0, n;
	always #2 clk = ~clk;
	daclu_core u_daclu_core (.CLOCK(clk), .RESET_N(rst_n), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.TRIG0(t0), .TRIG1(t1), .DMA_REQ(dreq), .DMA_ACK(dack),
		.DAC_LATCH(latch), .DAC_REF_SEL(refsel), .DAC_ENABLE(den),
		.IRQ(irq));
	daclu_dma_model u_daclu_dma_model (.clk(clk), .rst_n(rst_n),
		.delay(dly), .req(dreq), .ack(dack));
	// trigger k loads only with its select and the gate
	function logic ld(input int ls, input int en, input int k);
		return en == 1 && ls == 2 + k;
	endfunction : ld
	task finish_test();
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task chk(input string s, input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	// word-wide one-cycle accesses
	task w(input logic [3:0] a, input logic [15:0] x);
		@(posedge clk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : w
	task rc(input string s, input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(s, rdata, e);
	endtask : rc
	// trigger pulse, long enough for the synchroniser
	task pulse(input logic a, input logic b);
		@(posedge clk);
		t0 <= a;
		t1 <= b;
		repeat (4) @(posedge clk);
		t0 <= 1'b0;
		t1 <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
	endtask : pulse
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			finish_test();
		end
	end
	// main sequence
	initial begin
		void'($urandom(32'hdc73));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++)
			rc("reset", 4'(2 * i), 16'(i == 6));
		w(4'h4, 16'h0006);
		repeat (8) begin
			d = 12'($urandom);
			dly <= 4'($urandom);
			w(4'h6, {4'hF, d});
			chk("latch", 16'(latch), 16'(d));
			chk("req", 16'(dreq), 16'h1);
			chk("irq", 16'(irq), 16'h1);
			for (n = 0; n < 24 && dreq === 1'b1; n++) begin
				@(posedge clk);
				#1;
			end
			chk("dmaclr", 16'(irq), 16'h0);
			rc("sample", 4'h6, 16'(d));
		end
		w(4'h4, 16'h0002);
		w(4'h6, 16'h0123);
		chk("req", 16'(dreq), 16'h0);
		rc("vec", 4'hA, 16'h0004);
		rc("vec", 4'hA, 16'h0000);
		w(4'h6, 16'h0456);
		w(4'h8, 16'h0000);
		chk("w0", 16'(irq), 16'h1);
		w(4'h8, 16'h0001);
		chk("w1", 16'(irq), 16'h0);
		w(4'h4, 16'h1003);
		chk("ref", {refsel, den}, 16'h3);
		w(4'h6, 16'h0789);
		w(4'h8, 16'h0001);
		chk("lock", 16'(irq), 16'h1);
		w(4'h4, 16'h0000);
		chk("ref", {refsel, den}, 16'h2);
		w(4'h8, 16'h0001);
		chk("w1", 16'(irq), 16'h0);
		for (int i = 0; i < 12; i++) begin
			w(4'h4, {2'h0, 1'(i / 3 % 2), 3'h0, 2'(i % 3 + 1), 8'h00});
			o = latch;
			d = ~latch;
			w(4'h6, 16'(d));
			chk("nowr", 16'(latch), 16'(o));
			pulse(i / 6 == 0, i / 6 == 1);
			chk("trig", 16'(latch), 16'(ld(i % 3 + 1, i / 3 % 2, i / 6)
				? d : o));
		end
		// mask register gates the interrupt output
		w(4'h4, 16'h0002);
		w(4'h6, 16'h0001);
		w(4'hC, 16'h0000);
		chk("mask0", 16'(irq), 16'h0);
		rc("mask", 4'hC, 16'h0000);
		w(4'hC, 16'h0001);
		chk("mask1", 16'(irq), 16'h1);
		finish_test();
	end
endmodule : tb
